// ==== inc/tmr8_pkg.sv ====
// shared constants and types of the 8-bit compare/pwm timer
package tmr8_pkg;

    // register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
    localparam logic [2:0] ADDR_COUNT_VALUE = 3'h1;
    localparam logic [2:0] ADDR_COMPARE_VALUE = 3'h2;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
    localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h4;

    // bit positions in mask and flag registers
    localparam int OVERFLOW_BIT = 0;
    localparam int COMPARE_BIT = 1;

    // counter limits
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // values after reset
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam logic [7:0] RESET_COMPARE = 8'h00;
    localparam logic [1:0] RESET_MASK = 2'h0;
    localparam logic [1:0] RESET_FLAGS = 2'h0;

    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIRECT = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // prescaler taps: 8, 64, 256, 1024
    localparam int PRESC_W = 10;
    localparam int PRESC_TAPS = 4;
    localparam logic [9:0] TAP_MASK [PRESC_TAPS] = '{10'h007, 10'h03f, 10'h0ff, 10'h3ff};
    localparam logic [9:0] PRESC_RESET = 10'h000;

    // compare output mode codes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // waveform mode, {mode bit 6, mode bit 3}
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE_PWM = 2'b01,
        MODE_CLEAR_ON_MATCH = 2'b10,
        MODE_FAST_PWM = 2'b11
    } tmr8_mode_t;

    // control register a layout
    typedef struct packed {
        logic force_compare_strobe;
        logic waveform_mode_hi_bit;
        logic [1:0] compare_output_mode;
        logic waveform_mode_low_bit;
        logic [2:0] clock_select_field;
    } tmr8_ctrl_t;

    // pin drive group
    typedef struct packed {
        logic level;
        logic enable;
    } tmr8_pin_t;

endpackage

// ==== tb/tb.sv ====
// self-checking bench for the 8-bit compare/pwm timer
`timescale 1ns/1ps
module tb import tmr8_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic gie = 1'b0;
    logic cack = 1'b0;
    logic oack = 1'b0;
    logic ext = 1'b0;
    logic pdir = 1'b0;
    logic pdat = 1'b0;
    logic [7:0] rdata;
    logic cirq, oirq, pin, oe;
    int error_cnt = 0;
    int samples_checked = 0;
    int div [5] = '{1, 8, 64, 256, 1024};
    logic [7:0] fc [5] = '{8'h90, 8'h90, 8'hb0, 8'ha0, 8'hb8};
    logic fp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #50 clk = ~clk;

    tmr8_core i_dut (
        .core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .global_irq_en_i(gie),
        .compare_irq_ack_i(cack), .overflow_irq_ack_i(oack), .compare_irq_o(cirq),
        .overflow_irq_o(oirq), .ext_count_pin_i(ext), .port_dir_i(pdir),
        .port_data_i(pdat), .waveform_out_pin_o(pin), .waveform_out_pin_oe_o(oe)
    );

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // rising then falling pin edge, four clocks each half
    task automatic edges(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            ext <= 1'b1;
            cyc(4);
            ext <= 1'b0;
            cyc(4);
        end
    endtask

    initial begin
        cyc(30000);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        cyc(6);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            rchk(3'(a), 8'h00);
        end
        @(posedge clk);
        pdir <= 1'b1;
        pdat <= 1'b1;
        cyc(3);
        #1;
        chk({7'h00, pin}, 8'h01);
        chk({7'h00, oe}, 8'h01);
        @(posedge clk);
        pdat <= 1'b0;
        // toggle, toggle, set, clear, then ignored in phase pwm
        for (int i = 0; i < 5; i++) begin
            wreg(ADDR_CONTROL_A, fc[i]);
            cyc(3);
            #1;
            chk({7'h00, pin}, {7'h00, fp[i]});
        end
        rchk(ADDR_CONTROL_A, 8'h38);
        wreg(ADDR_COUNT_VALUE, 8'h05);
        wreg(ADDR_COMPARE_VALUE, 8'h05);
        wreg(ADDR_CONTROL_A, 8'hc0);
        rchk(ADDR_COUNT_VALUE, 8'h05);
        rchk(ADDR_IRQ_FLAGS, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h01);
        @(posedge clk);
        gie <= 1'b1;
        wreg(ADDR_COUNT_VALUE, 8'hfe);
        wreg(ADDR_CONTROL_A, 8'h07);
        edges(2);
        rchk(ADDR_COUNT_VALUE, 8'h00);
        rchk(ADDR_IRQ_FLAGS, 8'h01);
        chk({7'h00, oirq}, 8'h01);
        wreg(ADDR_CONTROL_A, 8'h00);
        wreg(ADDR_IRQ_FLAGS, 8'h00);
        rchk(ADDR_IRQ_FLAGS, 8'h01);
        @(posedge clk);
        oack <= 1'b1;
        @(posedge clk);
        oack <= 1'b0;
        rchk(ADDR_IRQ_FLAGS, 8'h00);
        chk({7'h00, oirq}, 8'h00);
        wreg(ADDR_CONTROL_A, 8'h06);
        @(posedge clk);
        ext <= 1'b1;
        cyc(6);
        rchk(ADDR_COUNT_VALUE, 8'h00);
        @(posedge clk);
        ext <= 1'b0;
        cyc(6);
        rchk(ADDR_COUNT_VALUE, 8'h01);
        wreg(ADDR_CONTROL_A, 8'h00);
        wreg(ADDR_IRQ_FLAGS, 8'h03);
        wreg(ADDR_COMPARE_VALUE, 8'h02);
        wreg(ADDR_COUNT_VALUE, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h02);
        wreg(ADDR_CONTROL_A, 8'h47);
        edges(3);
        rchk(ADDR_COUNT_VALUE, 8'h00);
        rchk(ADDR_IRQ_FLAGS, 8'h02);
        chk({7'h00, cirq}, 8'h01);
        @(posedge clk);
        cack <= 1'b1;
        @(posedge clk);
        cack <= 1'b0;
        rchk(ADDR_IRQ_FLAGS, 8'h00);
        wreg(ADDR_COUNT_VALUE, 8'h02);
        edges(1);
        rchk(ADDR_COUNT_VALUE, 8'h03);
        rchk(ADDR_IRQ_FLAGS, 8'h00);
        rchk(ADDR_COMPARE_VALUE, 8'h02);
        wreg(ADDR_CONTROL_A, 8'h00);
        wreg(ADDR_IRQ_FLAGS, 8'h03);
        wreg(ADDR_COUNT_VALUE, 8'hfe);
        wreg(ADDR_CONTROL_A, 8'h6f);
        edges(3);
        #1;
        chk({7'h00, pin}, 8'h01);
        edges(3);
        #1;
        chk({7'h00, pin}, 8'h00);
        rchk(ADDR_IRQ_FLAGS, 8'h03);
        // phase pwm inverted: 10 ticks pass the rising match, 510 the falling one
        wreg(ADDR_CONTROL_A, 8'h00);
        wreg(ADDR_COMPARE_VALUE, 8'h03);
        wreg(ADDR_COUNT_VALUE, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wreg(ADDR_CONTROL_A, 8'h39);
            cyc(i ? 498 : 8);
            wreg(ADDR_CONTROL_A, 8'h38);
            cyc(2);
            #1;
            chk({7'h00, pin}, 8'(1 - i));
        end
        rchk(ADDR_COUNT_VALUE, 8'h00);
        // 16 divider periods between start and stop writes
        for (int i = 1; i < 6; i++) begin
            wreg(ADDR_COUNT_VALUE, 8'h00);
            wreg(ADDR_CONTROL_A, 8'(i));
            cyc(16 * div[i - 1] - 2);
            wreg(ADDR_CONTROL_A, 8'h00);
            rchk(ADDR_COUNT_VALUE, 8'h10);
        end
        report_and_stop();
    end
endmodule

// ==== tb/tmr8_core_chk.sv ====
// bound port assertions for the 8-bit compare/pwm timer
`timescale 1ns/1ps
module tmr8_core_chk import tmr8_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // interrupt handshake
    input wire logic global_irq_en_i,
    input wire logic overflow_irq_ack_i,
    input wire logic compare_irq_o,
    input wire logic overflow_irq_o,
    // pins
    input wire logic port_dir_i,
    input wire logic port_data_i,
    input wire logic waveform_out_pin_o,
    input wire logic waveform_out_pin_oe_o
);
    logic [2:0] cs_q;
    logic [1:0] com_q;
    logic [1:0] mask_q;
    tmr8_ctrl_t wr_ctrl;
    logic [1:0] com_next;
    assign wr_ctrl = tmr8_ctrl_t'(reg_wdata_i);
    // output mode as it applies to the pin at the coming edge
    assign com_next = (reg_wr_i && reg_addr_i == ADDR_CONTROL_A) ?
        wr_ctrl.compare_output_mode : com_q;
    // shadow of written control and mask fields
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cs_q <= CS_STOP;
            com_q <= COM_OFF;
            mask_q <= RESET_MASK;
        end else if (reg_wr_i && reg_addr_i == ADDR_CONTROL_A) begin
            cs_q <= wr_ctrl.clock_select_field;
            com_q <= wr_ctrl.compare_output_mode;
        end else if (reg_wr_i && reg_addr_i == ADDR_IRQ_MASK) begin
            mask_q <= reg_wdata_i[1:0];
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its slot");
    AST_FORCE_READ_ZERO: assert property (($past(reg_rd_i)
        && $past(reg_addr_i) == ADDR_CONTROL_A) |-> !reg_rdata_o[7])
        else $error("force strobe read as one");
    AST_MASK_READBACK: assert property (($past(reg_rd_i)
        && $past(reg_addr_i) == ADDR_IRQ_MASK) |-> reg_rdata_o == {6'h00, $past(mask_q)})
        else $error("mask read back wrong");
    AST_PIN_OE: assert property (!$past(reset_i)
        |-> waveform_out_pin_oe_o == $past(port_dir_i))
        else $error("pin enable does not follow direction");
    AST_PIN_PORT: assert property ((!$past(reset_i) && $past(com_next) == COM_OFF)
        |-> waveform_out_pin_o == $past(port_data_i))
        else $error("pin not on port data while output off");
    AST_CMP_IRQ_GIE: assert property (compare_irq_o |-> $past(global_irq_en_i))
        else $error("compare irq without global enable");
    AST_OVF_IRQ_GIE: assert property (overflow_irq_o |-> $past(global_irq_en_i))
        else $error("overflow irq without global enable");
    AST_OVF_ACK: assert property ((overflow_irq_ack_i && cs_q == CS_STOP)
        |-> ##2 !overflow_irq_o)
        else $error("overflow irq survives ack");
    AST_CMP_W1C: assert property ((reg_wr_i && reg_addr_i == ADDR_IRQ_FLAGS
        && reg_wdata_i[COMPARE_BIT] && cs_q == CS_STOP) |-> ##2 !compare_irq_o)
        else $error("compare irq survives write one");
endmodule

bind tmr8_core tmr8_core_chk i_chk (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .global_irq_en_i(global_irq_en_i),
    .overflow_irq_ack_i(overflow_irq_ack_i), .compare_irq_o(compare_irq_o),
    .overflow_irq_o(overflow_irq_o), .port_dir_i(port_dir_i),
    .port_data_i(port_data_i), .waveform_out_pin_o(waveform_out_pin_o),
    .waveform_out_pin_oe_o(waveform_out_pin_oe_o)
);

// ==== verilog/tmr8_core.sv ====
// 8-bit timer/counter with one compare channel and waveform output
`timescale 1ns/1ps
// Summary of operation
// RULE1: force strobe works only in non-pwm modes
// RULE2: force strobe applies compare action immediately
// RULE3: forced compare sets no flag, clears nothing
// RULE4: force strobe bit always reads zero
// RULE5: mode field picks normal, phase, clear-on-match, fast
// RULE6: compare write timing depends on mode
// RULE7: overflow at max, phase pwm at bottom
// RULE8: nonzero output mode takes the pin over
// RULE9: non-pwm match toggles, clears or sets output
// RULE10: fast pwm match and bottom output actions
// RULE11: fast pwm ignores match when compare equals top
// RULE12: phase pwm actions depend on count direction
// RULE13: phase pwm top compare acts at top
// RULE14: clock select stop, direct, four prescaler taps
// RULE15: codes six, seven count pin edges
// RULE16: pin edges count even when pin outputs
// RULE17: counter read/write, write blocks next match
// RULE18: compare register checked against counter
// RULE19: compare irq needs mask bit and global enable
// RULE20: overflow irq needs mask bit and global enable
// RULE21: compare flag set on match, cleared by ack
// RULE22: overflow flag cleared by ack or one
// RULE23: count pin synchronised, edge detected
// RULE24: counter increments, wraps or clears on match
module tmr8_core import tmr8_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // interrupt handshake with the cpu
    input wire logic global_irq_en_i,
    input wire logic compare_irq_ack_i,
    input wire logic overflow_irq_ack_i,
    output logic compare_irq_o,
    output logic overflow_irq_o,
    // board pins
    input wire logic ext_count_pin_i,
    input wire logic port_dir_i,
    input wire logic port_data_i,
    output logic waveform_out_pin_o,
    output logic waveform_out_pin_oe_o
);
    // register state
    tmr8_ctrl_t ctrl, next_ctrl;
    logic [7:0] counter_value, next_counter_value;
    logic [7:0] compare_value, next_compare_value;
    logic [7:0] compare_buf, next_compare_buf;
    logic [1:0] irq_mask, next_irq_mask;
    logic [1:0] irq_flags, next_irq_flags;
    logic [7:0] rdata, next_rdata;
    // timer state
    logic count_down, next_count_down;
    logic match_block, next_match_block;
    logic wave, next_wave;
    logic compare_irq, next_compare_irq;
    logic overflow_irq, next_overflow_irq;
    tmr8_pin_t pin, next_pin;

    // derived signals
    logic [PRESC_TAPS-1:0] taps;
    logic ext_rise, ext_fall;
    logic tick;
    logic hit;
    logic at_max;
    logic ovf_set;
    logic update_compare;
    logic force_now;
    tmr8_ctrl_t wr_ctrl;
    tmr8_mode_t mode;

    tmr8_prescaler #(
        .TAPS(PRESC_TAPS)
    ) u_prescaler (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tap_o(taps)
    );

    // pin sampled regardless of its direction [RULE16] [RULE23]
    tmr8_ext_sync u_ext_sync (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .pin_i(ext_count_pin_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // non-pwm compare action on the waveform level
    function automatic logic nonpwm_action(input logic [1:0] com, input logic cur);
        logic res;
        res = cur;
        unique case (com)
            COM_OFF: res = cur;
            COM_TOGGLE: res = !cur;
            COM_CLEAR: res = 1'b0;
            COM_SET: res = 1'b1;
        endcase
        return res;
    endfunction

    // timer clock enable selection
    // prescaler runs free, so a first prescaled tick lands 1 to n cycles after start
    always_comb begin
        tick = 1'b0;
        unique case (ctrl.clock_select_field)
            CS_STOP: tick = 1'b0; // [RULE14]
            CS_DIRECT: tick = 1'b1; // [RULE14]
            CS_DIV8: tick = taps[0]; // [RULE14]
            CS_DIV64: tick = taps[1]; // [RULE14]
            CS_DIV256: tick = taps[2]; // [RULE14]
            CS_DIV1024: tick = taps[3]; // [RULE14]
            CS_EXT_FALL: tick = ext_fall; // [RULE15]
            CS_EXT_RISE: tick = ext_rise; // [RULE15]
        endcase
    end

    // mode decode and compare detection
    // matches only count on timer ticks, so a stopped timer never flags
    always_comb begin
        mode = tmr8_mode_t'({ctrl.waveform_mode_hi_bit, ctrl.waveform_mode_low_bit}); // [RULE5]
        at_max = (counter_value == COUNT_MAX);
        hit = tick && (counter_value == compare_value) && !match_block; // [RULE18] [RULE17]
        wr_ctrl = tmr8_ctrl_t'(reg_wdata_i);
    end

    // counter, direction, output level and flags
    always_comb begin
        next_counter_value = counter_value;
        next_count_down = count_down;
        next_match_block = match_block;
        next_wave = wave;
        ovf_set = 1'b0;
        update_compare = 1'b0;
        force_now = 1'b0;
        if (tick) begin
            next_match_block = 1'b0;
            unique case (mode)
                MODE_NORMAL: begin
                    next_counter_value = counter_value + 8'h01; // [RULE24]
                    ovf_set = at_max; // [RULE7]
                    if (hit) begin
                        next_wave = nonpwm_action(ctrl.compare_output_mode, wave); // [RULE9]
                    end
                end
                MODE_CLEAR_ON_MATCH: begin
                    // top is the compare value
                    if (hit) begin
                        next_counter_value = COUNT_BOTTOM; // [RULE24] [RULE5]
                        next_wave = nonpwm_action(ctrl.compare_output_mode, wave); // [RULE9]
                    end else begin
                        next_counter_value = counter_value + 8'h01;
                    end
                    ovf_set = at_max; // [RULE7]
                end
                MODE_FAST_PWM: begin
                    next_counter_value = counter_value + 8'h01;
                    ovf_set = at_max; // [RULE7]
                    update_compare = at_max; // [RULE6]
                    if (ctrl.compare_output_mode[1]) begin
                        if (hit && compare_value != COUNT_MAX) begin
                            next_wave = ctrl.compare_output_mode[0]; // [RULE10] [RULE11]
                        end
                        if (at_max) begin
                            next_wave = !ctrl.compare_output_mode[0]; // [RULE10] [RULE11]
                        end
                    end
                end
                MODE_PHASE_PWM: begin
                    // direction turns at max and at bottom, one tick spent at each
                    if (!count_down) begin
                        if (at_max) begin
                            next_count_down = 1'b1;
                            next_counter_value = counter_value - 8'h01;
                            update_compare = 1'b1; // [RULE6]
                        end else begin
                            next_counter_value = counter_value + 8'h01;
                        end
                    end else begin
                        if (counter_value == COUNT_BOTTOM) begin
                            next_count_down = 1'b0;
                            next_counter_value = counter_value + 8'h01;
                            ovf_set = 1'b1; // [RULE7]
                        end else begin
                            next_counter_value = counter_value - 8'h01;
                        end
                    end
                    if (ctrl.compare_output_mode[1]) begin
                        if (compare_value == COUNT_MAX) begin
                            if (at_max) begin
                                next_wave = !ctrl.compare_output_mode[0]; // [RULE13]
                            end
                        end else if (hit) begin
                            // up-count match takes low mode bit, down-count its inverse
                            next_wave = count_down ? !ctrl.compare_output_mode[0]
                                                   : ctrl.compare_output_mode[0]; // [RULE12]
                        end
                    end
                end
            endcase
        end
        // software write to the counter wins and masks the next match
        if (reg_wr_i && reg_addr_i == ADDR_COUNT_VALUE) begin
            next_counter_value = reg_wdata_i; // [RULE17]
            next_match_block = 1'b1; // [RULE17]
        end
        // forced compare only in non-pwm modes, using the written mode bits
        if (reg_wr_i && reg_addr_i == ADDR_CONTROL_A && wr_ctrl.force_compare_strobe
            && !wr_ctrl.waveform_mode_low_bit) begin // [RULE1]
            force_now = 1'b1;
            next_wave = nonpwm_action(wr_ctrl.compare_output_mode, next_wave); // [RULE2]
        end
    end

    // software registers, flags and compare double buffer
    always_comb begin
        next_ctrl = ctrl;
        next_compare_buf = compare_buf;
        next_compare_value = compare_value;
        next_irq_mask = irq_mask;
        next_irq_flags = irq_flags;
        if (update_compare) begin
            next_compare_value = compare_buf; // [RULE6]
        end
        // outside pwm the buffer is bypassed, so a pending value goes live
        if (!ctrl.waveform_mode_low_bit) begin
            next_compare_value = compare_buf; // [RULE6]
        end
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_CONTROL_A: begin
                    next_ctrl = wr_ctrl;
                    next_ctrl.force_compare_strobe = 1'b0; // [RULE4]
                end
                ADDR_COMPARE_VALUE: begin
                    next_compare_buf = reg_wdata_i;
                    if (!ctrl.waveform_mode_low_bit) begin
                        next_compare_value = reg_wdata_i; // [RULE6]
                    end
                end
                ADDR_IRQ_MASK: next_irq_mask = reg_wdata_i[1:0];
                ADDR_IRQ_FLAGS: begin
                    // write one clears, zero leaves the flag
                    next_irq_flags = irq_flags & ~reg_wdata_i[1:0]; // [RULE21] [RULE22]
                end
                default: next_ctrl = ctrl;
            endcase
        end
        if (compare_irq_ack_i) begin
            next_irq_flags[COMPARE_BIT] = 1'b0; // [RULE21]
        end
        if (overflow_irq_ack_i) begin
            next_irq_flags[OVERFLOW_BIT] = 1'b0; // [RULE22]
        end
        // setting beats a clear in the same cycle; forced compare never sets
        if (hit) begin
            next_irq_flags[COMPARE_BIT] = 1'b1; // [RULE21] [RULE3]
        end
        if (ovf_set) begin
            next_irq_flags[OVERFLOW_BIT] = 1'b1; // [RULE7]
        end
    end

    // interrupt requests, read data and pin drive
    always_comb begin
        next_compare_irq = global_irq_en_i && irq_mask[COMPARE_BIT]
                           && irq_flags[COMPARE_BIT]; // [RULE19]
        next_overflow_irq = global_irq_en_i && irq_mask[OVERFLOW_BIT]
                            && irq_flags[OVERFLOW_BIT]; // [RULE20]
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_CONTROL_A: begin
                    next_rdata = ctrl;
                    next_rdata[7] = 1'b0; // [RULE4]
                end
                ADDR_COUNT_VALUE: next_rdata = counter_value; // [RULE17]
                ADDR_COMPARE_VALUE: next_rdata = compare_buf;
                ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
                ADDR_IRQ_FLAGS: next_rdata = {6'h00, irq_flags};
                default: next_rdata = 8'h00;
            endcase
        end
        if (next_ctrl.compare_output_mode != COM_OFF) begin
            next_pin.level = next_wave; // [RULE8]
        end else begin
            next_pin.level = port_data_i;
        end
        // direction bit gates the driver even while the timer owns the level
        next_pin.enable = port_dir_i; // [RULE8]
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl <= tmr8_ctrl_t'(RESET_CONTROL);
            counter_value <= RESET_COUNT;
            compare_value <= RESET_COMPARE;
            compare_buf <= RESET_COMPARE;
            irq_mask <= RESET_MASK;
            irq_flags <= RESET_FLAGS;
            rdata <= 8'h00;
            count_down <= 1'b0;
            match_block <= 1'b0;
            wave <= 1'b0;
            compare_irq <= 1'b0;
            overflow_irq <= 1'b0;
            pin <= '0;
        end else begin
            ctrl <= next_ctrl;
            counter_value <= next_counter_value;
            compare_value <= next_compare_value;
            compare_buf <= next_compare_buf;
            irq_mask <= next_irq_mask;
            irq_flags <= next_irq_flags;
            rdata <= next_rdata;
            count_down <= next_count_down;
            match_block <= next_match_block;
            wave <= next_wave;
            compare_irq <= next_compare_irq;
            overflow_irq <= next_overflow_irq;
            pin <= next_pin;
        end
    end

    assign reg_rdata_o = rdata;
    assign compare_irq_o = compare_irq;
    assign overflow_irq_o = overflow_irq;
    assign waveform_out_pin_o = pin.level;
    assign waveform_out_pin_oe_o = pin.enable;

    // force_now marks a forced compare; it deliberately feeds no flag
    logic unused_force;
    assign unused_force = force_now;
endmodule

// ==== verilog/tmr8_ext_sync.sv ====
// count pin synchroniser, glitch filter and edge detector
`timescale 1ns/1ps
module tmr8_ext_sync import tmr8_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // raw pin
    input wire logic pin_i,
    // edge pulses
    output logic rise_o,
    output logic fall_o
);
    logic s1, s2, s3, filt;
    logic next_filt;
    logic agree;

    always_comb begin
        agree = (s2 == s3);
        next_filt = agree ? s3 : filt;
        rise_o = agree && s3 && !filt;
        fall_o = agree && !s3 && filt;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            filt <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end
endmodule

// ==== verilog/tmr8_prescaler.sv ====
// free running prescaler with one pulse per tap
`timescale 1ns/1ps
module tmr8_prescaler import tmr8_pkg::*; #(
    parameter int TAPS = PRESC_TAPS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // tap pulses, one cycle each
    output logic [TAPS-1:0] tap_o
);
    logic [PRESC_W-1:0] cnt;
    logic [PRESC_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt + 10'h001;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt <= PRESC_RESET;
        end else begin
            cnt <= next_cnt;
        end
    end

    for (genvar i = 0; i < TAPS; i++) begin : g_tap
        assign tap_o[i] = ((cnt & TAP_MASK[i]) == TAP_MASK[i]);
    end
endmodule
